// [core/code_readout.sv]
// Serial programming port slice that lets a programmer read code memory.
// Assumes the programmer makes the port clock and keeps the command sequence.
// Notes on behaviour
// - Code memory is read by executing supplied table reads and shifting results out with the shift-out command.
// - The source address is split: upper byte into the table page, lower 16 bits into the read pointer.
// - Each iteration fetches two consecutive instruction words and shifts them out through the visibility register.
// - Two 24-bit instructions travel packed in three 16-bit visibility words.
// - Command 0001 shifts out the visibility register and 0000 executes the payload.
// - Command codes and payloads are shifted least significant bit first on the port clock and data pins.
// - The visibility register sits at data address 784h, the target of the write pointer.
`default_nettype none
module code_readout #(
  parameter int unsigned MEM_WORDS = 256
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        prog_port_clock,
  input  wire logic        prog_port_data_in,
  output var  logic        prog_port_data_out,
  output var  logic        prog_port_data_oe,
  input  wire logic        mem_wr_en,
  input  wire logic [23:0] mem_wr_addr,
  input  wire logic [23:0] mem_wr_data
);
  localparam int unsigned AW = (MEM_WORDS > 1) ? $clog2(MEM_WORDS) : 1;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (MEM_WORDS < 2 || (MEM_WORDS & (MEM_WORDS - 1)) != 0) begin : g_bad_depth
    $error("MEM_WORDS must be a power of two of at least 2");
  end

  // ----------------------------------------------------------------
  // Code memory
  // ----------------------------------------------------------------
  logic [23:0] code_mem [MEM_WORDS];

  // Loading port used by the core side to fill the array
  always_ff @(posedge mclk) begin
    if (mem_wr_en && (mem_wr_addr[23:1] < 23'(MEM_WORDS))) begin
      code_mem[mem_wr_addr[AW:1]] <= mem_wr_data;
    end
  end

  // Fetch one instruction word for a page and byte pointer
  function automatic logic [23:0] fetch_word(input logic [7:0] page, input logic [15:0] ptr);
    logic [23:0] eff;
    eff = {page, ptr};
    if (eff[23:1] < 23'(MEM_WORDS)) begin
      return code_mem[eff[AW:1]];
    end
    return readout_pkg::ERASED_WORD;
  endfunction

  // Merge a table read result into the visibility register when addressed
  function automatic logic [15:0] visi_merge(input logic [15:0] visi, input logic [15:0] wptr,
                                             input logic [15:0] data, input logic is_byte);
    logic [15:0] res;
    res = visi;
    if ({wptr[15:1], 1'b0} == readout_pkg::VISI_ADDR) begin
      if (!is_byte) begin
        res = data;
      end else if (wptr[0]) begin
        res[15:8] = data[7:0];
      end else begin
        res[7:0] = data[7:0];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  readout_pkg::core_state_s s_q;
  readout_pkg::core_state_s s_d;
  logic        rise;
  logic        fall;
  logic        bit_in;
  logic        exec;
  logic [23:0] payload;
  logic [23:0] word;
  logic [15:0] ptr;

  assign rise    = s_q.sync.clk_pipe[1] & ~s_q.sync.clk_pipe[0];
  assign fall    = ~s_q.sync.clk_pipe[1] & s_q.sync.clk_pipe[0];
  assign bit_in  = s_q.sync.dat_pipe[0];
  assign payload = {bit_in, s_q.sh[23:1]};
  assign exec    = rise && (s_q.st == readout_pkg::LINK_PAY) && (s_q.cnt == readout_pkg::PAYLOAD_LAST);

  // Next state: sampling, framing and instruction execution
  always_comb begin
    s_d  = s_q;
    word = readout_pkg::ERASED_WORD;
    ptr  = s_q.read_pointer_reg;
    s_d.sync.clk_pipe = {prog_port_clock, s_q.sync.clk_pipe[2:1]};
    s_d.sync.dat_pipe = {prog_port_data_in, s_q.sync.dat_pipe[1]};
    case (s_q.st)
      readout_pkg::LINK_CMD: begin
        if (rise) begin
          s_d.cmd = {bit_in, s_q.cmd[3:1]};
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == readout_pkg::CMD_LAST) begin
            s_d.cnt = 5'h00;
            if ({bit_in, s_q.cmd[3:1]} == readout_pkg::CMD_SHIFT) begin
              s_d.st = readout_pkg::LINK_WAIT;
              s_d.sh = {8'h00, s_q.visi};
            end else begin
              s_d.st = readout_pkg::LINK_PAY;
            end
          end
        end
      end
      readout_pkg::LINK_PAY: begin
        if (rise) begin
          s_d.sh  = payload;
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == readout_pkg::PAYLOAD_LAST) begin
            s_d.cnt = 5'h00;
            s_d.st  = readout_pkg::LINK_CMD;
            // Execute the received payload
            if (payload[23:20] == readout_pkg::OP_MOV_LIT_PREFIX) begin
              case (payload[3:0])
                readout_pkg::REG_SCRATCH:   s_d.scratch_work_reg  = payload[19:4];
                readout_pkg::REG_READ_PTR:  s_d.read_pointer_reg  = payload[19:4];
                readout_pkg::REG_WRITE_PTR: s_d.write_pointer_reg = payload[19:4];
                default: ;
              endcase
            end else begin
              case (payload)
                readout_pkg::OP_MOV_SCRATCH_PAGE: begin
                  s_d.table_page_reg = s_q.scratch_work_reg[7:0];
                end
                readout_pkg::OP_RD_LOW_NOINC, readout_pkg::OP_RD_LOW_POSTINC: begin
                  word     = fetch_word(s_q.table_page_reg, ptr);
                  s_d.visi = visi_merge(s_q.visi, s_q.write_pointer_reg, word[15:0], 1'b0);
                  if (payload == readout_pkg::OP_RD_LOW_POSTINC) begin
                    s_d.read_pointer_reg = 16'(ptr + readout_pkg::WORD_STEP);
                  end
                end
                readout_pkg::OP_RD_HIGH_POSTINC, readout_pkg::OP_RD_HIGH_PREINC: begin
                  if (payload == readout_pkg::OP_RD_HIGH_PREINC) begin
                    ptr = 16'(s_q.read_pointer_reg + readout_pkg::BYTE_STEP);
                  end
                  word = fetch_word(s_q.table_page_reg, ptr);
                  // Odd byte address reads the phantom byte
                  s_d.visi = visi_merge(s_q.visi, s_q.write_pointer_reg,
                                        {8'h00, ptr[0] ? readout_pkg::PHANTOM_BYTE : word[23:16]},
                                        1'b1);
                  s_d.read_pointer_reg = ptr;
                  if (payload == readout_pkg::OP_RD_HIGH_POSTINC) begin
                    s_d.read_pointer_reg  = 16'(ptr + readout_pkg::BYTE_STEP);
                    s_d.write_pointer_reg = 16'(s_q.write_pointer_reg + readout_pkg::BYTE_STEP);
                  end
                end
                default: ;                                                       // No-op and jump
              endcase
            end
          end
        end
      end
      readout_pkg::LINK_WAIT: begin
        if (rise) begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == readout_pkg::IDLE_LAST) begin
            s_d.cnt = 5'h00;
            s_d.st  = readout_pkg::LINK_OUT;
          end
        end
      end
      readout_pkg::LINK_OUT: begin
        if (rise) begin
          s_d.drive.out = s_q.sh[0];
          s_d.drive.oe  = 1'b1;
          s_d.sh        = {1'b0, s_q.sh[23:1]};
          s_d.cnt       = s_q.cnt + 5'h01;
          if (s_q.cnt == readout_pkg::VISI_LAST) begin
            s_d.cnt = 5'h00;
            s_d.st  = readout_pkg::LINK_DONE;
          end
        end
      end
      readout_pkg::LINK_DONE: begin
        // Release the pin after the programmer samples the last bit
        if (fall) begin
          s_d.drive.oe  = 1'b0;
          s_d.drive.out = 1'b0;
          s_d.st        = readout_pkg::LINK_CMD;
        end
      end
      default: begin
        s_d.st = readout_pkg::LINK_CMD;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q    <= '0;
      s_q.st <= readout_pkg::LINK_CMD;
    end else begin
      s_q <= s_d;
    end
  end

  assign prog_port_data_out = s_q.drive.out;
  assign prog_port_data_oe  = s_q.drive.oe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_drive_after_idle: assert property ($rose(s_q.drive.oe) |-> $past(s_q.st) == readout_pkg::LINK_OUT)
    else $error("Data pin driven outside the shift-out phase");
  chk_visi_from_exec: assert property ($changed(s_q.visi) |-> $past(exec))
    else $error("Visibility register changed without an executed read");
  chk_page_load: assert property (exec && payload == readout_pkg::OP_MOV_SCRATCH_PAGE
    |=> s_q.table_page_reg == $past(s_q.scratch_work_reg[7:0]))
    else $error("Table page not loaded from scratch register");
  chk_pointer_step: assert property (exec && payload == readout_pkg::OP_RD_HIGH_POSTINC
    |=> s_q.read_pointer_reg == 16'($past(s_q.read_pointer_reg) + readout_pkg::BYTE_STEP)
        && s_q.write_pointer_reg == 16'($past(s_q.write_pointer_reg) + readout_pkg::BYTE_STEP))
    else $error("Pointers not stepped by one byte");
  chk_packed_high: assert property (exec && payload == readout_pkg::OP_RD_HIGH_PREINC
    && s_q.write_pointer_reg == 16'(readout_pkg::VISI_ADDR + readout_pkg::BYTE_STEP) |=> $stable(s_q.visi[7:0]))
    else $error("High byte read disturbed the low byte");
  chk_lsb_first: assert property (rise && s_q.st == readout_pkg::LINK_OUT
    |=> prog_port_data_out == $past(s_q.sh[0]) ##1 prog_port_data_oe)
    else $error("Shift-out bit order wrong");
  chk_visi_address: assert property (exec && payload == readout_pkg::OP_RD_LOW_NOINC
    && {s_q.write_pointer_reg[15:1], 1'b0} != readout_pkg::VISI_ADDR |=> $stable(s_q.visi))
    else $error("Read landed in visibility register at wrong address");
endmodule
`default_nettype wire

// [core/readout_pkg.sv]
// Constants, states and carriers for the serial code memory readout port.
// Assumes a single core clock domain; the port clock arrives from the programmer.
`default_nettype none
package readout_pkg;
  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  localparam int unsigned CMD_BITS     = 4;
  localparam int unsigned PAYLOAD_BITS = 24;
  localparam int unsigned VISI_BITS    = 16;
  localparam int unsigned OUT_IDLE     = 8;
  localparam logic [3:0]  CMD_EXEC     = 4'h0;
  localparam logic [3:0]  CMD_SHIFT    = 4'h1;
  localparam logic [4:0]  CMD_LAST     = 5'(CMD_BITS - 1);
  localparam logic [4:0]  PAYLOAD_LAST = 5'(PAYLOAD_BITS - 1);
  localparam logic [4:0]  IDLE_LAST    = 5'(OUT_IDLE - 1);
  localparam logic [4:0]  VISI_LAST    = 5'(VISI_BITS - 1);

  // ----------------------------------------------------------------
  // Executed payloads
  // ----------------------------------------------------------------
  localparam logic [23:0] OP_NOP             = 24'h000000;
  localparam logic [7:0]  OP_GOTO_PREFIX     = 8'h04;
  localparam logic [3:0]  OP_MOV_LIT_PREFIX  = 4'h2;
  localparam logic [23:0] OP_MOV_SCRATCH_PAGE = 24'h880190;
  localparam logic [23:0] OP_RD_LOW_NOINC    = 24'hba0b96;
  localparam logic [23:0] OP_RD_HIGH_POSTINC = 24'hbadbb6;
  localparam logic [23:0] OP_RD_HIGH_PREINC  = 24'hbad3d6;
  localparam logic [23:0] OP_RD_LOW_POSTINC  = 24'hba0bb6;
  localparam logic [3:0]  REG_SCRATCH        = 4'h0;
  localparam logic [3:0]  REG_READ_PTR       = 4'h6;
  localparam logic [3:0]  REG_WRITE_PTR      = 4'h7;
  localparam logic [15:0] VISI_ADDR          = 16'h0784;
  localparam logic [15:0] BYTE_STEP          = 16'h0001;
  localparam logic [15:0] WORD_STEP          = 16'h0002;
  localparam logic [7:0]  PHANTOM_BYTE       = 8'h00;
  localparam logic [23:0] ERASED_WORD        = 24'hffffff;

  // ----------------------------------------------------------------
  // Link states and carriers
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    LINK_CMD  = 5'b00001,
    LINK_PAY  = 5'b00010,
    LINK_WAIT = 5'b00100,
    LINK_OUT  = 5'b01000,
    LINK_DONE = 5'b10000
  } link_st_e;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_s;

  typedef struct packed {
    logic [2:0] clk_pipe;   // Meta, sync, previous
    logic [1:0] dat_pipe;   // Meta, sync
  } pin_sync_s;

  typedef struct packed {
    link_st_e   st;
    logic [4:0] cnt;
    logic [3:0] cmd;
    logic [23:0] sh;
    logic [15:0] scratch_work_reg;
    logic [15:0] read_pointer_reg;
    logic [15:0] write_pointer_reg;
    logic [7:0]  table_page_reg;
    logic [15:0] visi;
    pin_sync_s   sync;
    pin_drive_s  drive;
  } core_state_s;
endpackage
`default_nettype wire

// [tb/prog_model.sv]
// Programmer model for the serial code memory readout port.
// Assumes the core clock is shared with the bench; port clock stands low outside frames.
`default_nettype none
module prog_model (
  input  wire logic mclk,
  input  wire logic data_line,
  input  wire logic dev_oe,
  output logic      port_clk,
  output logic      host_out,
  output logic      host_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Bit level
  // ----------------------------------------------------------------
  initial begin
    port_clk = 1'b0;
    host_out = 1'b0;
    host_oe  = 1'b1;
  end

  // One port clock period of 8 core clocks; called just after an edge with the clock low
  task automatic send_bit(input logic b);
    host_out = b;
    repeat (4) @(posedge mclk);
    #1 port_clk = 1'b1;
    repeat (4) @(posedge mclk);
    #1 port_clk = 1'b0;
  endtask

  // Execute frame: code then payload, both LSB first
  task automatic exec(input logic [23:0] p);
    for (int i = 0; i < 4; i++) send_bit(readout_pkg::CMD_EXEC[i]);
    for (int i = 0; i < 24; i++) send_bit(p[i]);
  endtask

  // Shift frame: line released, 8 idle clocks, 16 bits sampled on falling edges
  task automatic shift(output logic [15:0] v, output logic ok);
    ok = 1'b1;
    for (int i = 0; i < 4; i++) send_bit(readout_pkg::CMD_SHIFT[i]);
    host_oe = 1'b0;
    for (int i = 0; i < 24; i++) begin
      repeat (4) @(posedge mclk);
      #1 port_clk = 1'b1;
      repeat (4) @(posedge mclk);
      #1 if (dev_oe !== (i >= 8)) ok = 1'b0;
      if (i >= 8) v[i-8] = data_line;
      port_clk = 1'b0;
    end
    repeat (5) @(posedge mclk);
    #1 if (dev_oe !== 1'b0) ok = 1'b0;
    host_oe = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Command sequences
  // ----------------------------------------------------------------
  // Leave reset vector, load page, read and write pointers
  task automatic setup(input logic [23:0] a);
    exec(readout_pkg::OP_NOP);
    exec({readout_pkg::OP_GOTO_PREFIX, 16'h0200});
    exec(readout_pkg::OP_NOP);
    exec({readout_pkg::OP_MOV_LIT_PREFIX, 8'h00, a[23:16], readout_pkg::REG_SCRATCH});
    exec(readout_pkg::OP_MOV_SCRATCH_PAGE);
    exec({readout_pkg::OP_MOV_LIT_PREFIX, a[15:0], readout_pkg::REG_READ_PTR});
    exec({readout_pkg::OP_MOV_LIT_PREFIX, readout_pkg::VISI_ADDR, readout_pkg::REG_WRITE_PTR});
    exec(readout_pkg::OP_NOP);
  endtask

  // Table read followed by two no-ops
  task automatic rd(input logic [23:0] op);
    exec(op);
    exec(readout_pkg::OP_NOP);
    exec(readout_pkg::OP_NOP);
  endtask

  // One iteration: two instructions out through three visibility words
  task automatic read_iter(output logic [23:0] i0, output logic [23:0] i1, output logic ok);
    logic [15:0] w1;
    logic [15:0] w2;
    logic [15:0] w3;
    logic        k;
    rd(readout_pkg::OP_RD_LOW_NOINC);
    shift(w1, ok);
    exec(readout_pkg::OP_NOP);
    rd(readout_pkg::OP_RD_HIGH_POSTINC);
    rd(readout_pkg::OP_RD_HIGH_PREINC);
    shift(w2, k);
    ok &= k;
    exec(readout_pkg::OP_NOP);
    rd(readout_pkg::OP_RD_LOW_POSTINC);
    shift(w3, k);
    ok &= k;
    exec(readout_pkg::OP_NOP);
    exec({readout_pkg::OP_GOTO_PREFIX, 16'h0200});
    exec(readout_pkg::OP_NOP);
    i0 = {w2[7:0], w1};
    i1 = {w2[15:8], w3};
  endtask
endmodule
`default_nettype wire

// [tb/test_serial_code_memory_readout.sv]
// Self-checking bench for the code memory readout port.
// Assumes the programmer model in prog_model and a 256-word code memory.
`default_nettype none
module test_serial_code_memory_readout;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        mclk;
  logic        rst_n;
  logic        mem_wr_en;
  logic [23:0] mem_wr_addr;
  logic [23:0] mem_wr_data;
  logic        port_clk;
  logic        host_out;
  logic        host_oe;
  logic        last_q;
  logic        dout;
  logic        doe;
  logic        line;
  logic [23:0] img [256];
  int          fail_count;
  int          n_tests;

  // Wire level from all drivers; a released line shows the inverse of its last level
  assign line = doe ? dout : (host_oe ? host_out : ~last_q);
  always @(posedge mclk) last_q <= line;

  code_readout #(.MEM_WORDS(256)) dut (
    .mclk               (mclk),
    .rst_n              (rst_n),
    .prog_port_clock    (port_clk),
    .prog_port_data_in  (line),
    .prog_port_data_out (dout),
    .prog_port_data_oe  (doe),
    .mem_wr_en          (mem_wr_en),
    .mem_wr_addr        (mem_wr_addr),
    .mem_wr_data        (mem_wr_data)
  );

  prog_model m (
    .mclk      (mclk),
    .data_line (line),
    .dev_oe    (doe),
    .port_clk  (port_clk),
    .host_out  (host_out),
    .host_oe   (host_oe)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // Expected instruction at a byte address; beyond the memory reads as erased
  function automatic logic [23:0] expw(input logic [23:0] a);
    return (a[23:9] == 15'h0000) ? img[a[8:1]] : readout_pkg::ERASED_WORD;
  endfunction

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One iteration, optionally after a fresh address setup
  task automatic iter(input logic [23:0] a, input logic do_setup);
    logic [23:0] i0;
    logic [23:0] i1;
    logic        ok;
    // The high byte read leaves the write pointer one byte on, so a repeat points it back first
    if (do_setup) begin
      m.setup(a);
    end else begin
      m.exec({readout_pkg::OP_MOV_LIT_PREFIX, readout_pkg::VISI_ADDR, readout_pkg::REG_WRITE_PTR});
      m.exec(readout_pkg::OP_NOP);
    end
    m.read_iter(i0, i1, ok);
    check("first instruction", expw(a), i0);
    check("second instruction", expw(a + 24'h2), i1);
    check("pin enable window", 24'h1, {23'h0, ok});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_load();
    for (int i = 0; i < 256; i++) begin
      img[i] = {8'(i) ^ 8'h5a, 8'(i), ~8'(i)};
      @(posedge mclk);
      #1 mem_wr_en = 1'b1;
      mem_wr_addr = {15'h0, 8'(i), 1'b0};
      mem_wr_data = img[i];
    end
    @(posedge mclk);
    #1 mem_wr_en = 1'b0;
  endtask

  task automatic s_idle_after_reset();
    #1;
    check("data out after reset", 24'h0, {23'h0, dout});
    check("enable after reset", 24'h0, {23'h0, doe});
  endtask

  task automatic s_read_repeat();
    iter(24'h000010, 1'b1);
    iter(24'h000014, 1'b0);
  endtask

  // A word read aimed away from the visibility register leaves it untouched
  task automatic s_foreign_target();
    logic [23:0] keep;
    logic [15:0] v;
    logic        ok;
    keep = expw(24'h000016);
    m.exec({readout_pkg::OP_MOV_LIT_PREFIX, 16'h0800, readout_pkg::REG_WRITE_PTR});
    m.exec(readout_pkg::OP_NOP);
    m.rd(readout_pkg::OP_RD_LOW_NOINC);
    m.shift(v, ok);
    m.exec(readout_pkg::OP_NOP);
    check("visibility kept", {8'h00, keep[15:0]}, {8'h00, v});
    check("kept pin enable window", 24'h1, {23'h0, ok});
  endtask

  task automatic s_page_split();
    iter(24'h010010, 1'b1);
  endtask

  task automatic s_top_of_memory();
    iter(24'h0001fc, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    wrap_up();
  end

  initial begin
    rst_n       = 1'b0;
    mem_wr_en   = 1'b0;
    mem_wr_addr = 24'h000000;
    mem_wr_data = 24'h000000;
    last_q      = 1'b0;
    fail_count  = 0;
    n_tests     = 0;
    repeat (20) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    s_idle_after_reset();
    s_load();
    s_read_repeat();
    s_foreign_target();
    s_page_split();
    s_top_of_memory();
    wrap_up();
  end
endmodule
`default_nettype wire
